// [hdl/fpc_top.sv]
// Flash program/erase sequencer with its APB control register.
// Assumes RST_N_I is the power-on reset and SYS_RST_N_I any other reset.
// Operation
// - Setting start launches the operation; hardware clears start when done.
// - Bad sequence or early termination, reset included, sets the error flag.
// - Select bit chooses erase or program for the next start.
// - Erase 1111 bulk, 1101 general, 1100 secure; 1110,1011,0011 reserved.
// - Erase codes 0010 page, 0001 nothing, 0000 configuration byte erase.
// - Program 0011 word, 0001 row, 0000 config byte; 1111,1101,1100,0010 nothing.
// - Any other code is unimplemented and runs no flash operation.
// - Control fields clear only on power-on reset; the code also clears start when SYS_RST_N_I aborts an operation.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "fpc_map.svh"

module fpc_top
    import fpc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES  = `FPC_PROG_CYC,
    parameter int unsigned ERASE_CYCLES = `FPC_ERASE_CYC
) (
    // Clock and resets
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    input  wire logic        SYS_RST_N_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Flash array command
    output logic             FLASH_REQ_O,
    output logic             FLASH_ERASE_O,
    output logic      [3:0]  FLASH_CMD_O
);
    fpc_op_if op ();

    logic        start_r;
    logic        permit_r;
    logic        err_r;
    logic        erase_r;
    logic [3:0]  op_r;
    logic [31:0] prdata_r;
    fpc_kind_e   cmd_r;
    logic        flash_erase_r;

    logic        addr_hit;
    logic        wr_acc;
    logic        start_req;
    logic        launch;
    logic        bad_seq;
    logic        abort;
    logic        err_set;
    fpc_kind_e   kind;
    logic [15:0] ctrl_rd;

    // Bus decode; zero wait states, unmapped addresses answer with error
    assign addr_hit  = (PADDR_I == `FPC_CTRL_OFF);
    assign wr_acc    = PSEL_I && PENABLE_I && PWRITE_I && addr_hit;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_hit;

    // Operation chosen from the stored fields, not from the start write
    assign kind      = fpc_decode(erase_r, op_r);
    assign start_req = wr_acc && PWDATA_I[`FPC_START_BIT] && !start_r;
    assign launch    = start_req && permit_r && SYS_RST_N_I
                       && (kind != K_BAD) && (kind != K_NONE);
    assign bad_seq   = start_req && (!permit_r || kind == K_BAD);
    assign abort     = !SYS_RST_N_I && start_r;
    assign err_set   = bad_seq || abort;

    // Timer side of the handshake
    assign op.go        = launch;
    assign op.abort     = abort;
    assign op.erase_sel = erase_r;

    // Start bit: software sets, only completion or abort clears
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            start_r <= 1'b0;
        end else if (launch) begin
            start_r <= 1'b1;
        end else if (op.done || abort) begin
            start_r <= 1'b0;
        end
    end

    // Permit bit stays writable so software can drop it mid-operation
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            permit_r <= 1'b0;
        end else if (wr_acc) begin
            permit_r <= PWDATA_I[`FPC_PERMIT_BIT];
        end
    end

    // Error flag: hardware set wins over a software write
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            err_r <= 1'b0;
        end else if (err_set) begin
            err_r <= 1'b1;
        end else if (wr_acc) begin
            err_r <= PWDATA_I[`FPC_ERR_BIT];
        end
    end

    // Select and code frozen while busy so the array sees one command
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            erase_r <= 1'b0;
            op_r    <= 4'h0;
        end else if (wr_acc && !start_r) begin
            erase_r <= PWDATA_I[`FPC_ERASE_BIT];
            op_r    <= PWDATA_I[`FPC_OP_MSB:`FPC_OP_LSB];
        end
    end

    // Command latched at launch and withdrawn at the end
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            cmd_r         <= K_NONE;
            flash_erase_r <= 1'b0;
        end else if (launch) begin
            cmd_r         <= kind;
            flash_erase_r <= erase_r;
        end else if (op.done || abort) begin
            cmd_r         <= K_NONE;
            flash_erase_r <= 1'b0;
        end
    end

    // Readback image, unused positions tied low
    assign ctrl_rd = {start_r, permit_r, err_r, 6'h00, erase_r, 2'h0,
                      op_r};

    // Read data registered in the setup phase, valid in the access phase
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            prdata_r <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            prdata_r <= addr_hit ? {16'h0000, ctrl_rd} : 32'h0000_0000;
        end
    end

    fpc_op_timer #(
        .PROG_CYCLES  (PROG_CYCLES),
        .ERASE_CYCLES (ERASE_CYCLES)
    ) u_timer (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .op      (op)
    );

    assign PRDATA_O      = prdata_r;
    assign FLASH_REQ_O   = op.busy;
    assign FLASH_ERASE_O = flash_erase_r;
    assign FLASH_CMD_O   = cmd_r;

    // Checks
    sequence s_running;
        start_r && FLASH_REQ_O;
    endsequence

    sequence s_idle_flash;
        !start_r && !FLASH_REQ_O;
    endsequence

    property p_launch;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        launch |=> s_running ##1 start_r;
    endproperty
    a_launch: assert property (p_launch)
        else $error("launch did not start operation");

    property p_start_sticky;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        start_r && !op.done && SYS_RST_N_I |=> start_r;
    endproperty
    a_start_sticky: assert property (p_start_sticky)
        else $error("start cleared before completion");

    property p_abort;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        abort |=> s_idle_flash and err_r;
    endproperty
    a_abort: assert property (p_abort)
        else $error("reset abort not flagged");

    property p_select;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        launch |=> FLASH_ERASE_O == $past(erase_r);
    endproperty
    a_select: assert property (p_select)
        else $error("erase select not passed to flash");

    property p_bulk;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        launch && erase_r && op_r == `FPC_OP_BULK |=> FLASH_CMD_O == K_BULK;
    endproperty
    a_bulk: assert property (p_bulk)
        else $error("bulk erase code misdecoded");

    property p_erase_nop;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        start_req && erase_r && op_r == `FPC_OP_ONE && !start_r
            |=> s_idle_flash [*2];
    endproperty
    a_erase_nop: assert property (p_erase_nop)
        else $error("erase no-op ran the flash");

    property p_word;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        launch && !erase_r && op_r == `FPC_OP_WORD
            |=> FLASH_CMD_O == K_WORD && !FLASH_ERASE_O;
    endproperty
    a_word: assert property (p_word)
        else $error("word program code misdecoded");

    property p_bad_code;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        start_req && kind == K_BAD |=> s_idle_flash and err_r;
    endproperty
    a_bad_code: assert property (p_bad_code)
        else $error("unimplemented code not refused");

    property p_keep_fields;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !SYS_RST_N_I && !wr_acc |=> $stable({permit_r, erase_r, op_r});
    endproperty
    a_keep_fields: assert property (p_keep_fields)
        else $error("fields lost on non power-on reset");

    property p_permit;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        start_req && !permit_r |=> s_idle_flash and err_r;
    endproperty
    a_permit: assert property (p_permit)
        else $error("start accepted without permit");

    property p_unused_zero;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        PSEL_I && PENABLE_I && !PWRITE_I
            |-> PRDATA_O[12:7] == 6'h00 && PRDATA_O[5:4] == 2'h0
                && PRDATA_O[31:16] == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits read non-zero");
endmodule

// [include/fpc_map.svh]
// Register map, field positions, operation codes and timing counts
// for the flash program/erase sequencer. Definitions only.
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH

// Register offsets on the 8-bit APB address
`define FPC_ADDR_W       8
`define FPC_CTRL_OFF     8'h00
`define FPC_CTRL_RST     16'h0000

// Control register field positions
`define FPC_START_BIT    15
`define FPC_PERMIT_BIT   14
`define FPC_ERR_BIT      13
`define FPC_ERASE_BIT    6
`define FPC_OP_MSB       3
`define FPC_OP_LSB       0

// Operation codes
`define FPC_OP_BULK      4'hF
`define FPC_OP_RSV_E     4'hE
`define FPC_OP_GEN       4'hD
`define FPC_OP_SEC       4'hC
`define FPC_OP_RSV_B     4'hB
`define FPC_OP_WORD      4'h3
`define FPC_OP_PAGE      4'h2
`define FPC_OP_ONE       4'h1
`define FPC_OP_CFG       4'h0

// Default self-timed durations in system clock cycles
`define FPC_PROG_CYC     32'h0000_0040
`define FPC_ERASE_CYC    32'h0000_0100

`endif

// [include/fpc_pkg.sv]
// Types and the operation-code decoder for the flash sequencer.
// Needs fpc_map.svh on the include path.
`include "fpc_map.svh"

package fpc_pkg;

    // Flash operations the sequencer can run
    typedef enum logic [3:0] {
        K_NONE, K_BULK, K_GEN, K_SEC, K_PAGE, K_CFG_ER,
        K_WORD, K_ROW, K_CFG_PR, K_BAD
    } fpc_kind_e;

    // Map select bit and operation code onto an operation
    function automatic fpc_kind_e fpc_decode(input logic       erase,
                                             input logic [3:0] op);
        fpc_kind_e k;
        k = K_BAD;
        if (erase) begin
            case (op)
                `FPC_OP_BULK: k = K_BULK;
                `FPC_OP_GEN:  k = K_GEN;
                `FPC_OP_SEC:  k = K_SEC;
                `FPC_OP_PAGE: k = K_PAGE;
                `FPC_OP_ONE:  k = K_NONE;
                `FPC_OP_CFG:  k = K_CFG_ER;
                default:      k = K_BAD;
            endcase
        end else begin
            case (op)
                `FPC_OP_WORD: k = K_WORD;
                `FPC_OP_ONE:  k = K_ROW;
                `FPC_OP_CFG:  k = K_CFG_PR;
                `FPC_OP_BULK,
                `FPC_OP_GEN,
                `FPC_OP_SEC,
                `FPC_OP_PAGE: k = K_NONE;
                default:      k = K_BAD;
            endcase
        end
        return k;
    endfunction

endpackage

// [include/fpc_op_if.sv]
// Handshake between the sequencer control and its operation timer.
// Both ends run on the same system clock.
`timescale 1ns/10ps

interface fpc_op_if;
    logic go;        // Launch pulse
    logic abort;     // Early termination
    logic erase_sel; // Erase timing when high
    logic busy;      // Operation running
    logic done;      // Last busy cycle, one pulse

    modport ctl (output go, abort, erase_sel, input busy, done);
    modport tmr (input go, abort, erase_sel, output busy, done);
endinterface

// [hdl/fpc_op_timer.sv]
// Self-timed operation timer for the flash sequencer.
// Assumes go arrives only while idle; abort wins over everything.
`timescale 1ns/10ps
`include "fpc_map.svh"

module fpc_op_timer #(
    parameter int unsigned PROG_CYCLES  = `FPC_PROG_CYC,
    parameter int unsigned ERASE_CYCLES = `FPC_ERASE_CYC
) (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link to control
    fpc_op_if.tmr    op
);
    localparam int unsigned MAXC = (PROG_CYCLES > ERASE_CYCLES) ?
                                   PROG_CYCLES : ERASE_CYCLES;
    localparam int CW = $clog2(MAXC + 1);

    logic [CW-1:0] cnt_r;
    logic          busy_r;

    // Count down the operation length, N busy cycles per launch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_r <= 1'b0;
            cnt_r  <= '0;
        end else if (op.abort) begin
            busy_r <= 1'b0;
        end else if (op.go && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r  <= op.erase_sel ? CW'(ERASE_CYCLES - 1) :
                                     CW'(PROG_CYCLES - 1);
        end else if (busy_r) begin
            if (cnt_r == '0) begin
                busy_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // Done is combinational so control clears its start bit in step
    assign op.busy = busy_r;
    assign op.done = busy_r && (cnt_r == '0) && !op.abort;

    property p_done_drop;
        @(posedge clk_i) disable iff (!rst_n_i)
        op.done |=> !busy_r;
    endproperty
    a_done_drop: assert property (p_done_drop)
        else $error("timer busy after done");
endmodule

// [sim/fpc_top_test.sv]
// Self-checking bench for the flash program/erase sequencer.
// Assumes a zero-wait APB slave at offset 0 and a 40 MHz system clock.
`timescale 1ns/10ps
`include "fpc_map.svh"

module fpc_top_test
    import fpc_pkg::*;
;
    // Short op times keep the run brief; erase must outlast the abort test
    localparam int unsigned PROG_N  = 5;
    localparam int unsigned ERASE_N = 12;
    localparam logic [31:0] START   = 32'h0000_8000;
    localparam logic [31:0] PERMIT  = 32'h0000_4000;
    localparam logic [31:0] ERR     = 32'h0000_2000;
    localparam logic [31:0] ERASE   = 32'h0000_0040;

    logic        clk_sys   = 1'b0;
    logic        rst_n     = 1'b0;
    logic        sys_rst_n = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        flash_req;
    logic        flash_erase;
    logic [3:0]  flash_cmd;
    logic [31:0] q;
    logic [31:0] cfg;
    logic [3:0]  k;
    logic        e;
    logic        run;
    int          n;
    int          cycles    = 0;
    int          err_count = 0;
    int          compares  = 0;

    fpc_top #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) i_fpc_top (
        .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .SYS_RST_N_I(sys_rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FLASH_REQ_O(flash_req),
        .FLASH_ERASE_O(flash_erase), .FLASH_CMD_O(flash_cmd)
    );

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("[ERR] %0t timeout", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rq,
                       output logic re);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] d);
        apb(1'b1, `FPC_CTRL_OFF, d, q, e);
    endtask

    task automatic rd(input logic [31:0] exp, input string msg);
        apb(1'b0, `FPC_CTRL_OFF, 32'h0000_0000, q, e);
        chk(q, exp, msg);
    endtask

    // Expected operation for {select, code}
    function automatic logic [3:0] exp_kind(input logic [4:0] m);
        case (m)
            5'h1F: return K_BULK;
            5'h1D: return K_GEN;
            5'h1C: return K_SEC;
            5'h12: return K_PAGE;
            5'h10: return K_CFG_ER;
            5'h03: return K_WORD;
            5'h01: return K_ROW;
            5'h00: return K_CFG_PR;
            5'h11, 5'h0F, 5'h0D, 5'h0C, 5'h02: return K_NONE;
            default: return K_BAD;
        endcase
    endfunction

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(32'h0000_0000, "reset value");
        // Unused positions never stick
        wr(32'hFFFF_1FB0);
        rd(32'h0000_0000, "unused bits");
        // Unmapped address is refused
        apb(1'b0, 8'h04, 32'h0000_0000, q, e);
        chk(e, 1'b1, "unmapped err");
        chk(q, 32'h0000_0000, "unmapped data");
        // Start without permit runs nothing and flags a sequence error
        wr(ERASE | 32'h0000_000F);
        wr(ERASE | 32'h0000_000F | START);
        @(negedge clk_sys);
        chk(flash_req, 1'b0, "no permit req");
        rd(ERR | ERASE | 32'h0000_000F, "no permit flag");
        // Every code in both modes
        for (int m = 0; m < 32; m++) begin
            cfg = PERMIT | {25'h0, m[4], 2'h0, m[3:0]};
            k   = exp_kind(m[4:0]);
            run = (k != K_NONE) && (k != K_BAD);
            wr(cfg);
            wr(cfg | START);
            @(negedge clk_sys);
            chk(flash_req, run, "launch");
            chk(flash_cmd, run ? k : K_NONE, "kind");
            chk(flash_erase, run & m[4], "mode");
            n = 0;
            while (flash_req === 1'b1 && n < 100) begin
                @(negedge clk_sys);
                n++;
            end
            chk(n, run ? (m[4] ? ERASE_N : PROG_N) : 0, "duration");
            rd(cfg | ((k == K_BAD) ? ERR : 0), "after op");
        end
        // Running op: start cannot be cleared, fields locked, reset aborts
        cfg = PERMIT | ERASE | 32'h0000_000F;
        wr(cfg);
        wr(cfg | START);
        wr(PERMIT | ERASE | 32'h0000_0002);
        rd(cfg | START, "start held");
        @(posedge clk_sys);
        sys_rst_n <= 1'b0;
        @(posedge clk_sys);
        sys_rst_n <= 1'b1;
        @(negedge clk_sys);
        chk(flash_req, 1'b0, "abort req");
        chk(flash_cmd, K_NONE, "abort cmd");
        rd(cfg | ERR, "abort flag kept");
        // Only power-on reset clears the fields
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(32'h0000_0000, "power-on clear");
        finish_test();
    end
endmodule
